/* File: logic/afc_defines.vh */
// Purpose: Constants for the automatic flow control trigger block.
// Assumes: Included by afc_trigger.v only; definitions only.
// Notes: Times are in nanoseconds, offsets are byte addresses.
`ifndef AFC_DEFINES_VH
`define AFC_DEFINES_VH

// Register byte offsets
`define AFC_CFG_OFS 8'h00
`define AFC_STAT_OFS 8'h04

// Config field positions
`define AFC_ANY_BIT 0
`define AFC_ADDR_BIT 1
`define AFC_BCAST_BIT 2
`define AFC_MCAST_BIT 3
`define AFC_DUR_LSB 4
`define AFC_DUR_MSB 7
`define AFC_CFG_W 8
`define AFC_CFG_RST 8'h00

// Status field positions
`define AFC_ST_LEVEL_BIT 0
`define AFC_ST_JAM_BIT 1
`define AFC_ST_PEND_BIT 2
`define AFC_ST_SENT_BIT 3

// Threshold granule: 64 bytes, a shift of 6
`define AFC_THR_SHIFT 6

// Jam durations at 100 Mbps, ns
`define AFC_JAM_C0_NS 5000
`define AFC_JAM_C1_NS 10000
`define AFC_JAM_C2_NS 15000
`define AFC_JAM_C3_NS 25000
`define AFC_JAM_STEP_NS 50000
`define AFC_JAM_STEP_BASE 3
// Extra time added at 10 Mbps, and the whole code 0 time at 10 Mbps, ns
`define AFC_JAM_10M_EXTRA_NS 2200
`define AFC_JAM_10M_C0_NS 7200

// Clock period, ns
`define AFC_CLK_PERIOD_NS 8

`endif

/* File: logic/afc_trigger.v */
// Purpose: Automatic flow control trigger, jam timer and pause request.
// Assumes: MAC side inputs are on CLK_I; classic Wishbone register slave.
// Notes: Threshold and pause time arrive from neighbouring registers.
//   Config writes land on the acknowledge edge; status is read only.
//   Jam and pause outputs each lag their cause by two clock edges.
//   JAM_DIV shortens the jam periods for simulation only.
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "afc_defines.vh"

module afc_trigger #(
  parameter FIFO_AW = 16,
  parameter PAUSE_W = 16,
  parameter JAM_DIV = 1,
  parameter JAM_CW = 17
) (
  input wire CLK_I,
  input wire RSTN_I,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  input wire FULL_DUPLEX_I,
  input wire SPEED_10_I,
  input wire [FIFO_AW-1:0] RX_FIFO_USED_I,
  input wire [7:0] FIFO_HIGH_THRESHOLD_I,
  input wire [PAUSE_W-1:0] PAUSE_TIME_VALUE_I,
  input wire RX_PREAMBLE_I,
  input wire RX_DA_VALID_I,
  input wire RX_DA_MULTICAST_I,
  input wire RX_DA_BROADCAST_I,
  input wire RX_DA_MATCH_I,
  input wire TX_BUSY_I,
  output reg JAM_O,
  output reg PAUSE_START_O,
  output reg [PAUSE_W-1:0] PAUSE_TIME_O
);

  // Jam period in clock cycles for a duration code and speed
  function [JAM_CW-1:0] jam_cycles;
    input [3:0] code;
    input slow;
    reg [31:0] ns;
    reg [31:0] cyc;
    begin
      ns = 32'h0;
      cyc = 32'h0;
      case (code)
        4'h0: ns = `AFC_JAM_C0_NS;
        4'h1: ns = `AFC_JAM_C1_NS;
        4'h2: ns = `AFC_JAM_C2_NS;
        4'h3: ns = `AFC_JAM_C3_NS;
        default: ns = ({28'h0, code} - `AFC_JAM_STEP_BASE) * `AFC_JAM_STEP_NS;
      endcase
      // 10 Mbps adds a fixed margin
      if (slow) begin
        if (code == 4'h0)
          ns = `AFC_JAM_10M_C0_NS;
        else
          ns = ns + `AFC_JAM_10M_EXTRA_NS;
      end
      // JAM_DIV only exists so simulation can shorten the period
      cyc = ns / `AFC_CLK_PERIOD_NS / JAM_DIV;
      if (cyc == 32'h0)
        cyc = 32'h1;
      jam_cycles = cyc[JAM_CW-1:0];
    end
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  // Only the synchronised copy resets the logic below
  wire rst_n = rst_sync_r;

  // Config, timer and pause flag state
  reg [`AFC_CFG_W-1:0] cfg_r;
  reg jam_r;
  reg [JAM_CW-1:0] jam_cnt_r;
  reg [JAM_CW-1:0] jam_cnt_nxt;
  reg jam_nxt;
  reg pend_r;
  reg pend_nxt;
  reg sent_r;
  reg sent_nxt;

  // Trigger selection fields
  wire trig_any = cfg_r[`AFC_ANY_BIT];
  wire trig_addr = cfg_r[`AFC_ADDR_BIT];
  wire trig_bcast = cfg_r[`AFC_BCAST_BIT];
  wire trig_mcast = cfg_r[`AFC_MCAST_BIT];
  wire [3:0] dur_sel = cfg_r[`AFC_DUR_MSB:`AFC_DUR_LSB];

  // Threshold scaled to bytes; wide enough for 255 * 64
  wire [FIFO_AW+7:0] used_w = {8'h00, RX_FIFO_USED_I};
  wire [FIFO_AW+7:0] thr_bytes =
    {{FIFO_AW{1'b0}}, FIFO_HIGH_THRESHOLD_I} << `AFC_THR_SHIFT;
  // A threshold of zero counts as always reached
  wire level_hi = (used_w >= thr_bytes);

  // Wishbone access decode
  wire bus_req = CYC_I & STB_I & ~ACK_O;
  // Writes land on the edge that sees ACK_O high with the request
  // still held, the one edge at which the master ends the cycle
  wire bus_done = CYC_I & STB_I & ACK_O;
  wire wr_cfg = bus_done & WE_I & SEL_I[0] & (ADR_I == `AFC_CFG_OFS);
  wire rd_req = bus_req & ~WE_I;

  // Status word, one bit per flag
  function [31:0] status_word;
    input level;
    input jam;
    input pend;
    input sent;
    begin
      status_word = 32'h0000_0000;
      status_word[`AFC_ST_LEVEL_BIT] = level;
      status_word[`AFC_ST_JAM_BIT] = jam;
      status_word[`AFC_ST_PEND_BIT] = pend;
      status_word[`AFC_ST_SENT_BIT] = sent;
    end
  endfunction

  // Half duplex frame qualifier
  reg hd_hit;
  always @* begin
    hd_hit = 1'b0;
    if (trig_any) begin
      hd_hit = RX_PREAMBLE_I;
    end else if (RX_DA_VALID_I) begin
      hd_hit = (trig_mcast & RX_DA_MULTICAST_I) |
               (trig_bcast & RX_DA_BROADCAST_I) |
               (trig_addr & RX_DA_MATCH_I);
    end
  end

  // A qualifying frame while the level stands loads the timer
  wire jam_load = level_hi & hd_hit;
  wire [JAM_CW-1:0] jam_one = {{(JAM_CW-1){1'b0}}, 1'b1};

  // Jam timer next state
  always @* begin
    jam_nxt = jam_r;
    jam_cnt_nxt = jam_cnt_r;
    if (FULL_DUPLEX_I) begin
      // Jamming never runs in full duplex
      jam_nxt = 1'b0;
      jam_cnt_nxt = {JAM_CW{1'b0}};
    end else if (jam_load) begin
      // Every matching frame restarts the jam
      jam_nxt = 1'b1;
      jam_cnt_nxt = jam_cycles(dur_sel, SPEED_10_I);
    end else if (jam_r) begin
      // Count down; the last count drops the jam
      if (jam_cnt_r == jam_one)
        jam_nxt = 1'b0;
      jam_cnt_nxt = jam_cnt_r - jam_one;
    end
  end

  // Full duplex enable: the any-frame bit alone
  wire fdx_en = FULL_DUPLEX_I & trig_any;
  // Pause leaves only into an idle transmitter, still in full duplex
  wire pause_go = pend_r & ~TX_BUSY_I & FULL_DUPLEX_I;

  // Full duplex pause request next state
  always @* begin
    pend_nxt = pend_r;
    sent_nxt = sent_r;
    // Crossing re-arms only after the level falls away
    if (!level_hi)
      sent_nxt = 1'b0;
    // Pending pause waits for an idle transmitter
    if (pause_go)
      pend_nxt = 1'b0;
    // A pause frame has no meaning once the link is half duplex
    if (!FULL_DUPLEX_I)
      pend_nxt = 1'b0;
    // Any-frame is the full duplex enable
    // Request at once on reaching the level
    if (fdx_en & level_hi & ~sent_r & ~pend_r) begin
      pend_nxt = 1'b1;
      sent_nxt = 1'b1;
    end
  end

  // Trigger bits writable, cleared by reset
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `AFC_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= DAT_I[`AFC_CFG_W-1:0];
    end
  end

  // Jam timer and pause flags
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      jam_r <= 1'b0;
      jam_cnt_r <= {JAM_CW{1'b0}};
      pend_r <= 1'b0;
      sent_r <= 1'b0;
    end else begin
      jam_r <= jam_nxt;
      jam_cnt_r <= jam_cnt_nxt;
      pend_r <= pend_nxt;
      sent_r <= sent_nxt;
    end
  end

  // Back pressure output, one flop behind the timer
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      JAM_O <= 1'b0;
    end else begin
      JAM_O <= jam_r;
    end
  end

  // One-cycle start only while transmit is idle
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PAUSE_START_O <= 1'b0;
    end else begin
      PAUSE_START_O <= pause_go;
    end
  end

  // Pause time captured as the request starts; held after
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PAUSE_TIME_O <= {PAUSE_W{1'b0}};
    end else if (pause_go) begin
      PAUSE_TIME_O <= PAUSE_TIME_VALUE_I;
    end
  end

  // Wishbone ack: one cycle after the strobe, never back to back
  // A strobe held past the ack is taken again two cycles later
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ACK_O <= 1'b0;
    end else begin
      ACK_O <= bus_req;
    end
  end

  // Read data stands only in the ack cycle, zero otherwise
  // Unmapped addresses read zero and ignore writes rather than stall
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      DAT_O <= 32'h0000_0000;
    end else begin
      DAT_O <= 32'h0000_0000;
      if (rd_req) begin
        case (ADR_I)
          `AFC_CFG_OFS: DAT_O <= {24'h00_0000, cfg_r};
          `AFC_STAT_OFS: DAT_O <= status_word(level_hi, jam_r, pend_r,
            sent_r);
          default: DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/afc_props.sv */
// Purpose: Port checks for the flow control trigger.
// Assumes: Bound onto afc_trigger, one clock.
// Notes: Duplex is held steady around pause traffic.
`timescale 1ns/1ps
`default_nettype none
module afc_props #(parameter PAUSE_W = 16) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic [31:0] DAT_O,
  input wire logic FULL_DUPLEX_I,
  input wire logic TX_BUSY_I,
  input wire logic RX_PREAMBLE_I,
  input wire logic RX_DA_VALID_I,
  input wire logic [PAUSE_W-1:0] PAUSE_TIME_VALUE_I,
  input wire logic JAM_O,
  input wire logic PAUSE_START_O,
  input wire logic [PAUSE_W-1:0] PAUSE_TIME_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Bus answers, one cycle wide
  a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("no ack");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("data outside ack");
  // Jam is seen two samples after its cause
  a_jam_cause: assert property ($rose(JAM_O) |->
    $past(RX_DA_VALID_I || RX_PREAMBLE_I, 2))
    else $error("jam without hit");
  a_jam_fdx: assert property (FULL_DUPLEX_I [*3] |-> !JAM_O)
    else $error("jam in full duplex");
  // Pause only into an idle transmitter
  a_pause_idle: assert property (PAUSE_START_O |-> !$past(TX_BUSY_I))
    else $error("pause while busy");
  a_pause_fdx: assert property (PAUSE_START_O |-> $past(FULL_DUPLEX_I))
    else $error("pause in half duplex");
  a_pause_val: assert property (PAUSE_START_O |->
    PAUSE_TIME_O == $past(PAUSE_TIME_VALUE_I))
    else $error("pause time wrong");
  a_pause_one: assert property (PAUSE_START_O |=> !PAUSE_START_O)
    else $error("pause pulse long");
endmodule
bind afc_trigger afc_props #(.PAUSE_W(PAUSE_W)) u_props (.CLK_I, .RSTN_I,
  .CYC_I, .STB_I, .ACK_O, .DAT_O, .FULL_DUPLEX_I, .TX_BUSY_I,
  .RX_PREAMBLE_I, .RX_DA_VALID_I, .PAUSE_TIME_VALUE_I, .JAM_O,
  .PAUSE_START_O, .PAUSE_TIME_O);
`default_nettype wire

/* File: testbench/afc_tx_model.sv */
// Purpose: Transmitter model that drives the busy flag.
// Assumes: Pause start is a one-cycle pulse.
// Notes: A pause frame holds the line busy 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module afc_tx_model (
  input wire logic clk_i,
  input wire logic frame_i,
  input wire logic pause_i,
  output logic busy_o,
  output int n_pause_o
);
  logic [4:0] cnt_r = 5'h00;
  int n_pause_r = 0;
  always @(posedge clk_i) begin
    if (pause_i) begin
      n_pause_r <= n_pause_r + 1;
      cnt_r <= 5'h10;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
  assign busy_o = frame_i || (cnt_r != 5'h00);
  assign n_pause_o = n_pause_r;
endmodule
`default_nettype wire

/* File: testbench/afc_trigger_bench.sv */
// Purpose: Bench for afc_trigger.
// Assumes: JAM_DIV of 100, threshold of two granules.
// Notes: Codes and speed come from an LFSR.
`timescale 1ns/1ps
`default_nettype none
module afc_trigger_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic fd = 1'b0;
  logic slow = 1'b0;
  logic pre = 1'b0;
  logic dav = 1'b0;
  logic frame = 1'b0;
  logic [2:0] flg = 3'h0;
  logic [7:0] adr = 8'h00;
  logic [7:0] lf = 8'h3f;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic [15:0] used = 16'h0;
  logic [15:0] pt = 16'h0;
  wire [31:0] dout;
  wire ack, jam, pst, busy;
  wire [15:0] ptime;
  int n_errors = 0;
  int compares = 0;
  int np;
  afc_trigger #(.JAM_DIV(100)) u_dut (.CLK_I(clk), .RSTN_I(rstn),
    .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf),
    .DAT_I(wd), .DAT_O(dout), .ACK_O(ack), .FULL_DUPLEX_I(fd),
    .SPEED_10_I(slow), .RX_FIFO_USED_I(used),
    .FIFO_HIGH_THRESHOLD_I(8'h02), .PAUSE_TIME_VALUE_I(pt),
    .RX_PREAMBLE_I(pre), .RX_DA_VALID_I(dav), .RX_DA_MULTICAST_I(flg[2]),
    .RX_DA_BROADCAST_I(flg[1]), .RX_DA_MATCH_I(flg[0]), .TX_BUSY_I(busy),
    .JAM_O(jam), .PAUSE_START_O(pst), .PAUSE_TIME_O(ptime));
  afc_tx_model u_tx (.clk_i(clk), .frame_i(frame), .pause_i(pst),
    .busy_o(busy), .n_pause_o(np));
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Jam cycles at 800 ns per tick, rounded down
  function automatic int jam_len(input logic [3:0] c, input logic s);
    int ns;
    ns = (c == 0) ? 5000 : (c == 1) ? 10000 : (c == 2) ? 15000 :
      (c == 3) ? 25000 : (c - 3) * 50000;
    return (ns + (s ? 2200 : 0)) / 800;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dout;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  // Write config, fire one hit, measure the jam length
  task automatic try_jam(input logic [7:0] c, input logic p, input logic d,
    input logic [2:0] f, input logic [15:0] u, input int e);
    int n;
    n = 0;
    used <= u;
    wb(1'b1, 8'h00, {24'h0, c});
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, {24'h0, c});
    flg <= f;
    pre <= p;
    dav <= d;
    @(posedge clk);
    pre <= 1'b0;
    dav <= 1'b0;
    // Jam output rises on the second edge after the hit
    @(posedge clk);
    #1;
    while (jam === 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Back onto the edge before anything is driven again
    @(posedge clk);
    chk(n, e);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h08, 32'hff);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    // Each trigger kind with a random code and speed, at the exact level
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      slow <= lf[0];
      try_jam({lf[7:4], 4'h1 << i}, i == 0, i != 0, 3'h1 << (i - 1),
        16'h0080, jam_len(lf[7:4], lf[0]));
    end
    try_jam(8'h38, 1'b0, 1'b1, 3'h4, 16'h007f, 0);
    try_jam(8'h0f, 1'b0, 1'b1, 3'h7, 16'h0080, 0);
    // Triggers off first, or any-frame would pause at once
    wb(1'b1, 8'h00, 32'h0);
    fd <= 1'b1;
    try_jam(8'h08, 1'b0, 1'b1, 3'h4, 16'h0080, 0);
    chk(np, 0);
    // Pause held back by a frame in progress
    frame <= 1'b1;
    pt <= {lf, 8'h5a};
    wb(1'b1, 8'h00, 32'h01);
    repeat (10) @(posedge clk);
    chk(np, 0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_000d);
    frame <= 1'b0;
    repeat (40) @(posedge clk);
    chk(np, 1);
    chk(ptime, {lf, 8'h5a});
    used <= 16'h0;
    repeat (4) @(posedge clk);
    used <= 16'h0080;
    repeat (40) @(posedge clk);
    chk(np, 2);
    report_and_stop;
  end
  // Watchdog: tests need about 2700 cycles
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
